/* File: bench/tai_host.sv */
// SMBus host model: register reads and writes, and alert response reads.
// Assumes the bench resolves SDA from every party's drive and a pull-up.
`timescale 1ns/1ns
`default_nettype none
module tai_host (
  output var  logic       scl,
  output var  logic       sda_rel,
  input  wire logic       sda_line,
  input  wire logic [8:0] rd_pat,
  output var  logic       rd_flag,
  output var  logic [7:0] rd_byte
);
  // Quarter of a 400 ns bit; SCL stands high between frames
  localparam int Q = 100;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    rd_flag = 1'b0;
    rd_byte = 8'h00;
  end
  // Eight bits and the ninth, MSB first; data moves only while SCL is low
  task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_rel = tx[i];
      #Q scl = 1'b1;
      #Q rx[i] = sda_line;
      #Q scl = 1'b0;
      #Q;
    end
  endtask : xbyte
  // One frame: START, address, up to two write bytes (pointer, then data, as n allows) or one read byte, STOP
  task automatic frame(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
                       input int n, output logic ack);
    logic [8:0] rx;
    sda_rel = 1'b0;
    #Q scl = 1'b0;
    #Q xbyte({a, 1'b1}, rx);
    ack = ~rx[0];
    if (!a[0] && n > 0) xbyte({p, 1'b1}, rx);
    if (!a[0] && n > 1) xbyte({d, 1'b1}, rx);
    if (a[0] && ack) begin
      xbyte(rd_pat, rx); // A rival sender may pull bits; bit 0 is the NACK that ends the read
      rd_byte = rx[8:1];
      rd_flag = 1'b1;
      #1 rd_flag = 1'b0;
    end
    sda_rel = 1'b0;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b1;
    #Q;
  endtask : frame
endmodule : tai_host
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the thermometer alarm logic with an SMBus host model.
// Assumes the conversion engine is played by the bench on the same clock.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       clock;
  logic       srst;
  logic       open_sense;
  logic       conv_start;
  logic       local_valid;
  logic [7:0] local_value;
  logic       remote_valid;
  logic [7:0] remote_value;
  logic       scl;
  logic       sda_rel;
  logic       rd_flag;
  logic [7:0] rd_byte;
  logic       sda_oe;
  logic       convert_enable;
  logic       alarm_pin_oe;
  logic       fs_oe;
  wire logic  sda_line;
  logic [7:0] exp_q[$];
  logic [7:0] h;
  logic [8:0] rd_pat = 9'h1FF;
  int         bad_count = 0;
  int         total_checks = 0;
  logic [31:0] seed = 32'h0000000D;
  // Pull-up wire: low when either party pulls
  assign sda_line = sda_rel & ~sda_oe;
  tai_host HOST (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line), .rd_pat(rd_pat),
                 .rd_flag(rd_flag), .rd_byte(rd_byte));
  tai_alarm DUT (.clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_o(),
    .sda_oe(sda_oe), .open_sense(open_sense), .conv_start(conv_start),
    .local_valid(local_valid), .local_value(local_value), .remote_valid(remote_valid),
    .remote_value(remote_value), .convert_enable(convert_enable), .alarm_pin_o(),
    .alarm_pin_oe(alarm_pin_oe), .failsafe_overtemp_n_o(), .failsafe_overtemp_n_oe(fs_oe));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // Each read byte is compared with the oldest expectation
  always @(posedge rd_flag) begin
    if (exp_q.size() > 0) check(rd_byte, exp_q.pop_front());
    else check(rd_byte, 8'hXX);
  end
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    logic ack;
    @(posedge clock) #1;
    HOST.frame({tai_pkg::SLAVE_ADDR, 1'b0}, p, d, 2, ack);
    check({7'h00, ack}, 8'h01);
  endtask : wreg
  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    logic ack;
    @(posedge clock) #1;
    HOST.frame({tai_pkg::SLAVE_ADDR, 1'b0}, p, 8'h00, 1, ack);
    exp_q.push_back(e);
    HOST.frame({tai_pkg::SLAVE_ADDR, 1'b1}, 8'h00, 8'h00, 0, ack);
  endtask : rreg
  // Alert response read; a refused one must stay unacknowledged
  task automatic ara(input logic e);
    logic ack;
    @(posedge clock) #1;
    // The wired line shows the AND of every sender
    if (e) exp_q.push_back({tai_pkg::SLAVE_ADDR, 1'b1} & rd_pat[8:1]);
    HOST.frame({tai_pkg::ARA_ADDR, 1'b1}, 8'h00, 8'h00, 0, ack);
    check({7'h00, ack}, {7'h00, e});
  endtask : ara
  task automatic conv(input logic [7:0] l);
    @(posedge clock) #1 conv_start = 1'b1;
    @(posedge clock) #1 conv_start = 1'b0;
    local_valid = 1'b1;
    local_value = l;
    @(posedge clock) #1 local_valid = 1'b0;
    remote_valid = 1'b1;
    remote_value = 8'h20;
    @(posedge clock) #1 remote_valid = 1'b0;
  endtask : conv
  // Pins settle within the three-clock lag (value, status, alarm, pin), so four clocks is a safe look
  task automatic pins(input logic [2:0] e);
    repeat (4) @(posedge clock);
    #1 check({7'h00, alarm_pin_oe}, {7'h00, e[2]});
    check({7'h00, fs_oe}, {7'h00, e[1]});
    check({7'h00, convert_enable}, {7'h00, e[0]});
  endtask : pins
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    test_done();
  end
  initial begin
    {srst, open_sense, conv_start, local_valid, remote_valid} = 5'h10;
    {local_value, remote_value} = 16'h0000;
    repeat (3) @(posedge clock);
    #1 srst = 1'b0;
    pins(3'h5);                       // Zero values sit on the zero low limits
    rreg(tai_pkg::RW_LFS, 8'h55);
    rreg(tai_pkg::RW_RFS, 8'h55);
    rreg(tai_pkg::RW_HYST, 8'h0A);
    rreg(8'h3E, 8'h00);
    conv(8'h56);
    pins(3'h7);
    ara(1'h1);
    pins(3'h7);
    rd_pat = 9'h123;                  // A rival at a lower address sends its byte and wins
    ara(1'h1);
    rd_pat = 9'h1FF;
    pins(3'h7);                       // Loser keeps its alarm
    conv(8'h4C);
    pins(3'h7);
    conv(8'h4B);
    pins(3'h5);
    rreg(tai_pkg::RD_STATUS, 8'h69);  // Low flags from reset stay until read
    ara(1'h1);
    pins(3'h1);
    ara(1'h0);
    wreg(tai_pkg::WR_CONFIG, 8'h40);
    pins(3'h0);
    wreg(tai_pkg::WR_LHIGH, 8'h30);
    pins(3'h4);
    open_sense = 1'b1;
    wreg(tai_pkg::WR_ONESHOT, rnd());
    pins(3'h5);
    conv(8'h4B);
    pins(3'h4);
    rreg(tai_pkg::RD_STATUS, 8'h44);
    wreg(tai_pkg::WR_CONFIG, 8'hC0);
    pins(3'h0);
    conv(8'h10);                      // Results offered in standby must be dropped
    rreg(tai_pkg::RD_LTEMP, 8'h4B);
    wreg(tai_pkg::WR_CONFIG, 8'h60);
    pins(3'h4);
    wreg(tai_pkg::WR_LHIGH, 8'h55);   // Fail-safe limits kept at or above highs
    pins(3'h0);
    wreg(tai_pkg::RW_LFS, 8'h40);
    pins(3'h2);
    h = rnd();
    wreg(tai_pkg::RW_HYST, h);
    rreg(tai_pkg::RW_HYST, h & 8'h1F);
    wreg(tai_pkg::WR_CONFIG, 8'h40);
    pins(3'h6);                       // Open flag and the still-latched local high flag raise the alarm
    test_done();
  end
endmodule : testbench
`default_nettype wire

/* File: design/tai_alarm.sv */
// Alarm, fail-safe and standby logic of a two-channel thermometer with its SMBus slave.
// Assumes pull-ups on the open-drain lines and a conversion engine on the same clock.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// [RL1] Alarm output pulls low on any limit violation or open remote sensor.
// [RL2] Alarm output is open drain: only pulls low or releases.
// [RL3] Host reads alert response address; an asserting device acknowledges it.
// [RL4] Alert response data byte is own 7-bit address with LSB 1.
// [RL5] Lowest address wins arbitration; losers keep alarm asserted.
// [RL6] After answering, alarm releases only if its cause is gone.
// [RL7] Host repeats alert response reads while the shared line stays low.
// [RL8] Configuration bit 6 selects standby; bus stays active in standby.
// [RL9] Entering standby aborts conversion; partial results never reach value registers.
// [RL10] Write to 0x0F in standby runs one conversion of both channels.
// [RL11] Limit writes in standby re-check stored values and can raise alarm.
// [RL12] Open comparator sampled at conversion start sets status bit 2.
// [RL13] Alarm when above high limit or at or below low limit.
// [RL14] Alarm output is maskable; fail-safe output has no mask.
// [RL15] Alarm clears only when cause gone, address read and status cleared.
// [RL16] Fail-safe output pulls low when either channel exceeds its fail-safe limit.
// [RL17] Both fail-safe limits reset to 85 degrees.
// [RL18] Fail-safe releases per channel at limit minus hysteresis, without host.
// [RL19] Hysteresis is unsigned, 1 degree steps, 0 to 31, reset 10.
// [RL20] Shared pin acts as alarm output or as second fail-safe output.
// [RL21] Second fail-safe uses high limits, no mask, same hysteresis release.
// [RL22] Software should set fail-safe limits at or above high limits.
// [RL23] Slave address is 0x4C, also reported in alert response.
// [RL24] Limit comparisons re-evaluate on every result and limit write.
module tai_alarm (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_o,
  output var  logic       sda_oe,
  input  wire logic       open_sense,
  input  wire logic       conv_start,
  input  wire logic       local_valid,
  input  wire logic [7:0] local_value,
  input  wire logic       remote_valid,
  input  wire logic [7:0] remote_value,
  output var  logic       convert_enable,
  output var  logic       alarm_pin_o,
  output var  logic       alarm_pin_oe,
  output var  logic       failsafe_overtemp_n_o,
  output var  logic       failsafe_overtemp_n_oe
);

  // Release point of a fail-safe comparison, floored at zero
  function automatic logic [7:0] tai_release(input logic [7:0] lim, input logic [4:0] hyst);
    logic [7:0] h;
    h = {3'h0, hyst};
    tai_release = (lim > h) ? lim - h : 8'h00;
  endfunction : tai_release

  logic             scl_m_reg, scl_reg, scl_d_reg;
  logic             sda_m_reg, sda_reg, sda_d_reg;
  logic             open_m_reg, open_reg;
  logic             scl_rise, scl_fall, bus_start, bus_stop;
  tai_pkg::tai_bus_e state_reg, state_next;
  logic [3:0]       cnt_reg, cnt_next;
  logic [7:0]       sh_reg, sh_next, tx_reg, tx_next, ptr_reg, ptr_next;
  logic             first_reg, first_next, rd_reg, rd_next, ara_reg, ara_next;
  logic             ack_ok_reg, ack_ok_next, bidx_reg, bidx_next;
  logic             sda_oe_reg, sda_oe_next;
  logic [7:0]       rx_byte, rd_data, tx_load;
  logic             wr_stb, st_clr, ara_ok;
  logic [7:0]       cfg_reg, cfg_next, lh_reg, lh_next, ll_reg, ll_next;
  logic [7:0]       rh_reg, rh_next, rl_reg, rl_next, lfs_reg, lfs_next, rfs_reg, rfs_next;
  logic [4:0]       hyst_reg, hyst_next;
  logic [7:0]       ltemp_reg, ltemp_next, rtemp_reg, rtemp_next, status_reg, status_next;
  logic             oneshot_reg, oneshot_next, conv_en_reg, conv_en_next;
  logic             open_flag_reg, open_flag_next;
  logic             fs_l_reg, fs_l_next, fs_r_reg, fs_r_next;
  logic             fs2_l_reg, fs2_l_next, fs2_r_reg, fs2_r_next;
  logic             alert_reg, alert_next, pin_oe_reg, failsafe_overtemp_n_oe_reg;
  logic             lhi, llo, rhi, rlo, alarm_cond;
  logic [7:0]       set_bits;

  // Two-stage synchronisers plus one delay stage for edge finding on the bus lines
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_m_reg  <= 1'h1;
      scl_reg    <= 1'h1;
      scl_d_reg  <= 1'h1;
      sda_m_reg  <= 1'h1;
      sda_reg    <= 1'h1;
      sda_d_reg  <= 1'h1;
      open_m_reg <= 1'h0;
      open_reg   <= 1'h0;
    end else begin
      scl_m_reg  <= scl_in;
      scl_reg    <= scl_m_reg;
      scl_d_reg  <= scl_reg;
      sda_m_reg  <= sda_in;
      sda_reg    <= sda_m_reg;
      sda_d_reg  <= sda_reg;
      open_m_reg <= open_sense;
      open_reg   <= open_m_reg;
    end
  end

  // Edges and bus conditions, all taken after synchronisation
  assign scl_rise  = scl_reg & ~scl_d_reg;
  assign scl_fall  = ~scl_reg & scl_d_reg;
  assign bus_start = scl_reg & scl_d_reg & sda_d_reg & ~sda_reg;
  assign bus_stop  = scl_reg & scl_d_reg & ~sda_d_reg & sda_reg;
  assign rx_byte   = {sh_reg[6:0], sda_reg};

  // Register read multiplexer; unmapped pointers read zero
  always_comb begin
    unique case (ptr_reg)
      tai_pkg::RD_LTEMP:  rd_data = ltemp_reg;
      tai_pkg::RD_RTEMP:  rd_data = rtemp_reg;
      tai_pkg::RD_STATUS: rd_data = status_reg;
      tai_pkg::RD_CONFIG: rd_data = cfg_reg;
      tai_pkg::RD_LHIGH:  rd_data = lh_reg;
      tai_pkg::RD_LLOW:   rd_data = ll_reg;
      tai_pkg::RD_RHIGH:  rd_data = rh_reg;
      tai_pkg::RD_RLOW:   rd_data = rl_reg;
      tai_pkg::RW_RFS:    rd_data = rfs_reg;
      tai_pkg::RW_LFS:    rd_data = lfs_reg;
      tai_pkg::RW_HYST:   rd_data = {3'h0, hyst_reg};
      default:            rd_data = 8'h00;
    endcase
  end

  // Alert response returns own address with a one below it
  assign tx_load = ara_reg ? {tai_pkg::SLAVE_ADDR, 1'h1} : rd_data; // [RL4] [RL23]

  // Bus engine: bytes in and out, acknowledge, arbitration on our own data
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    sh_next     = sh_reg;
    tx_next     = tx_reg;
    ptr_next    = ptr_reg;
    first_next  = first_reg;
    rd_next     = rd_reg;
    ara_next    = ara_reg;
    ack_ok_next = ack_ok_reg;
    bidx_next   = bidx_reg;
    sda_oe_next = sda_oe_reg;
    wr_stb      = 1'h0;
    st_clr      = 1'h0;
    ara_ok      = 1'h0;
    if (bus_stop) begin
      state_next  = tai_pkg::BUS_IDLE;
      sda_oe_next = 1'h0;
    end else if (bus_start) begin
      state_next  = tai_pkg::BUS_RX;
      cnt_next    = 4'h0;
      first_next  = 1'h1;
      sda_oe_next = 1'h0;
    end else begin
      unique case (state_reg)
        tai_pkg::BUS_IDLE: begin
        end
        tai_pkg::BUS_RX: begin
          if (scl_rise && cnt_reg != 4'h8) begin
            sh_next  = rx_byte;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'h7 && first_reg) begin
              rd_next     = sda_reg;
              ara_next    = (sh_reg[6:0] == tai_pkg::ARA_ADDR);
              ack_ok_next = (sh_reg[6:0] == tai_pkg::SLAVE_ADDR) ||
                            ((sh_reg[6:0] == tai_pkg::ARA_ADDR) && sda_reg && alert_reg); // [RL3]
              bidx_next   = 1'h0;
            end else if (cnt_reg == 4'h7) begin
              ack_ok_next = 1'h1;
              bidx_next   = 1'h1;
              if (!bidx_reg) begin
                ptr_next = rx_byte;
              end else begin
                wr_stb = 1'h1;
              end
            end
          end else if (scl_fall && cnt_reg == 4'h8) begin
            sda_oe_next = ack_ok_reg;
            state_next  = ack_ok_reg ? tai_pkg::BUS_ACK : tai_pkg::BUS_IDLE;
          end
        end
        tai_pkg::BUS_ACK: begin
          if (scl_fall) begin
            first_next = 1'h0;
            cnt_next   = 4'h0;
            if (rd_reg) begin
              tx_next     = {tx_load[6:0], 1'h1};
              sda_oe_next = ~tx_load[7];
              st_clr      = ~ara_reg && (ptr_reg == tai_pkg::RD_STATUS);
              state_next  = tai_pkg::BUS_TX;
            end else begin
              sda_oe_next = 1'h0;
              state_next  = tai_pkg::BUS_RX;
            end
          end
        end
        tai_pkg::BUS_TX: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
            if (!sda_oe_reg && !sda_reg) begin
              state_next = tai_pkg::BUS_IDLE; // [RL5]
            end else if (cnt_reg == 4'h7) begin
              ara_ok = ara_reg;
            end
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              sda_oe_next = 1'h0;
              state_next  = tai_pkg::BUS_TXACK;
            end else begin
              sda_oe_next = ~tx_reg[7];
              tx_next     = {tx_reg[6:0], 1'h1};
            end
          end
        end
        tai_pkg::BUS_TXACK: begin
          if (scl_rise) begin
            state_next = sda_reg ? tai_pkg::BUS_IDLE : tai_pkg::BUS_ACK;
          end
        end
        default: state_next = tai_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg  <= tai_pkg::BUS_IDLE;
      cnt_reg    <= 4'h0;
      sh_reg     <= 8'h00;
      tx_reg     <= 8'hFF;
      ptr_reg    <= 8'h00;
      first_reg  <= 1'h0;
      rd_reg     <= 1'h0;
      ara_reg    <= 1'h0;
      ack_ok_reg <= 1'h0;
      bidx_reg   <= 1'h0;
      sda_oe_reg <= 1'h0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      sh_reg     <= sh_next;
      tx_reg     <= tx_next;
      ptr_reg    <= ptr_next;
      first_reg  <= first_next;
      rd_reg     <= rd_next;
      ara_reg    <= ara_next;
      ack_ok_reg <= ack_ok_next;
      bidx_reg   <= bidx_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // Live comparisons on stored values, so a limit write re-checks at once
  assign lhi        = ltemp_reg > lh_reg;  // [RL13] [RL24] [RL11]
  assign llo        = ltemp_reg <= ll_reg; // [RL13]
  assign rhi        = rtemp_reg > rh_reg;
  assign rlo        = rtemp_reg <= rl_reg;
  assign alarm_cond = lhi | llo | rhi | rlo | open_flag_reg;
  assign set_bits   = {1'h0, lhi, llo, rhi, rlo, open_flag_reg, fs_r_reg, fs_l_reg};

  // Registers, conversion gating, status flags and alarm state
  always_comb begin
    cfg_next  = cfg_reg;
    lh_next   = lh_reg;
    ll_next   = ll_reg;
    rh_next   = rh_reg;
    rl_next   = rl_reg;
    lfs_next  = lfs_reg;
    rfs_next  = rfs_reg;
    hyst_next = hyst_reg;
    oneshot_next = oneshot_reg;
    // Remote result ends a round; a one-shot write in the same cycle still wins
    if (remote_valid && conv_en_reg) begin
      oneshot_next = 1'h0;
    end
    if (wr_stb) begin
      unique case (ptr_reg)
        tai_pkg::WR_CONFIG:  cfg_next  = rx_byte; // [RL8] [RL14] [RL20]
        tai_pkg::WR_LHIGH:   lh_next   = rx_byte;
        tai_pkg::WR_LLOW:    ll_next   = rx_byte;
        tai_pkg::WR_RHIGH:   rh_next   = rx_byte;
        tai_pkg::WR_RLOW:    rl_next   = rx_byte;
        tai_pkg::RW_RFS:     rfs_next  = rx_byte;
        tai_pkg::RW_LFS:     lfs_next  = rx_byte;
        tai_pkg::RW_HYST:    hyst_next = rx_byte[4:0]; // [RL19]
        tai_pkg::WR_ONESHOT: oneshot_next = oneshot_next | cfg_reg[tai_pkg::CFG_STBY]; // [RL10]
        default: begin
        end
      endcase
    end
    // Dropping results while disabled keeps aborted conversions out of the values
    ltemp_next = (local_valid && conv_en_reg) ? local_value : ltemp_reg;    // [RL9]
    rtemp_next = (remote_valid && conv_en_reg) ? remote_value : rtemp_reg;  // [RL9]
    conv_en_next   = ~cfg_next[tai_pkg::CFG_STBY] | oneshot_next; // [RL8]
    open_flag_next = (conv_start && conv_en_reg) ? open_reg : open_flag_reg; // [RL12]
    // Set beats clear-on-read so a violation in the read cycle survives
    status_next = (status_reg & ~{8{st_clr}}) | set_bits;
    // Fail-safe channels with hysteresis, released without host action
    fs_l_next  = fs_l_reg ? (ltemp_reg > tai_release(lfs_reg, hyst_reg)) : (ltemp_reg > lfs_reg); // [RL16] [RL18]
    fs_r_next  = fs_r_reg ? (rtemp_reg > tai_release(rfs_reg, hyst_reg)) : (rtemp_reg > rfs_reg); // [RL16] [RL18]
    fs2_l_next = fs2_l_reg ? (ltemp_reg > tai_release(lh_reg, hyst_reg)) : lhi; // [RL21]
    fs2_r_next = fs2_r_reg ? (rtemp_reg > tai_release(rh_reg, hyst_reg)) : rhi; // [RL21]
    // Alarm latches until answered with cause gone and status clear
    if (cfg_reg[tai_pkg::CFG_MASK] || cfg_reg[tai_pkg::CFG_PIN2]) begin
      alert_next = 1'h0; // [RL14]
    end else if (alert_reg) begin
      alert_next = !(ara_ok && !alarm_cond && ((status_next & tai_pkg::ALARM_BITS) == 8'h00)); // [RL6] [RL15]
    end else begin
      alert_next = |(status_reg & tai_pkg::ALARM_BITS); // [RL1]
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_reg       <= tai_pkg::CFG_RST;
      lh_reg        <= tai_pkg::HIGH_RST;
      ll_reg        <= tai_pkg::LOW_RST;
      rh_reg        <= tai_pkg::HIGH_RST;
      rl_reg        <= tai_pkg::LOW_RST;
      lfs_reg       <= tai_pkg::FS_RST; // [RL17]
      rfs_reg       <= tai_pkg::FS_RST; // [RL17]
      hyst_reg      <= tai_pkg::HYST_RST; // [RL19]
      ltemp_reg     <= 8'h00;
      rtemp_reg     <= 8'h00;
      status_reg    <= 8'h00;
      oneshot_reg   <= 1'h0;
      conv_en_reg   <= 1'h0;
      open_flag_reg <= 1'h0;
      fs_l_reg      <= 1'h0;
      fs_r_reg      <= 1'h0;
      fs2_l_reg     <= 1'h0;
      fs2_r_reg     <= 1'h0;
      alert_reg     <= 1'h0;
      pin_oe_reg    <= 1'h0;
      failsafe_overtemp_n_oe_reg  <= 1'h0;
    end else begin
      cfg_reg       <= cfg_next;
      lh_reg        <= lh_next;
      ll_reg        <= ll_next;
      rh_reg        <= rh_next;
      rl_reg        <= rl_next;
      lfs_reg       <= lfs_next;
      rfs_reg       <= rfs_next;
      hyst_reg      <= hyst_next;
      ltemp_reg     <= ltemp_next;
      rtemp_reg     <= rtemp_next;
      status_reg    <= status_next;
      oneshot_reg   <= oneshot_next;
      conv_en_reg   <= conv_en_next;
      open_flag_reg <= open_flag_next;
      fs_l_reg      <= fs_l_next;
      fs_r_reg      <= fs_r_next;
      fs2_l_reg     <= fs2_l_next;
      fs2_r_reg     <= fs2_r_next;
      alert_reg     <= alert_next;
      pin_oe_reg    <= cfg_reg[tai_pkg::CFG_PIN2] ? (fs2_l_reg | fs2_r_reg) : alert_reg; // [RL20]
      failsafe_overtemp_n_oe_reg  <= fs_l_reg | fs_r_reg; // [RL14]
    end
  end

  // Open-drain pins only ever drive low
  assign sda_o                  = 1'h0;
  assign sda_oe                 = sda_oe_reg;
  assign alarm_pin_o            = 1'h0; // [RL2]
  assign alarm_pin_oe           = pin_oe_reg;
  assign failsafe_overtemp_n_o  = 1'h0;
  assign failsafe_overtemp_n_oe = failsafe_overtemp_n_oe_reg;
  assign convert_enable         = conv_en_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_alert_raise: assert property ( // [RL1]
    !alert_reg && !cfg_reg[tai_pkg::CFG_MASK] && !cfg_reg[tai_pkg::CFG_PIN2] && open_flag_reg
    ##1 !cfg_reg[tai_pkg::CFG_MASK] && !cfg_reg[tai_pkg::CFG_PIN2] |=> alert_reg)
    else $error("alarm not raised on open sensor");
  chk_open_drain: assert property (!alarm_pin_o && !sda_o && !failsafe_overtemp_n_o) // [RL2]
    else $error("open-drain pin driven high");
  chk_ara_ack: assert property ( // [RL3]
    state_reg == tai_pkg::BUS_RX && cnt_reg == 4'h8 && scl_fall && ack_ok_reg
    |=> sda_oe && state_reg == tai_pkg::BUS_ACK)
    else $error("address not acknowledged");
  chk_ara_byte: assert property ( // [RL4]
    state_reg == tai_pkg::BUS_ACK && scl_fall && rd_reg && ara_reg && !bus_stop && !bus_start
    |=> tx_reg == {tai_pkg::SLAVE_ADDR[5:0], 2'h3} && !sda_oe)
    else $error("wrong alert response byte");
  chk_arb_loss: assert property ( // [RL5]
    state_reg == tai_pkg::BUS_TX && scl_rise && !sda_oe_reg && !sda_reg && !bus_stop
    |=> state_reg == tai_pkg::BUS_IDLE && !sda_oe)
    else $error("arbitration loss not honoured");
  chk_alert_hold: assert property ( // [RL6]
    alert_reg && alarm_cond && !cfg_reg[tai_pkg::CFG_MASK] && !cfg_reg[tai_pkg::CFG_PIN2]
    |=> alert_reg)
    else $error("alarm released while cause present");
  chk_abort_drop: assert property (!conv_en_reg && local_valid |=> $stable(ltemp_reg)) // [RL9]
    else $error("result taken while conversions stopped");
  chk_oneshot_go: assert property ( // [RL10]
    wr_stb && ptr_reg == tai_pkg::WR_ONESHOT && cfg_reg[tai_pkg::CFG_STBY] && !remote_valid
    |=> convert_enable)
    else $error("one-shot did not start conversion");
  chk_open_flag: assert property (conv_start && conv_en_reg && open_reg |=> ##1 status_reg[2]) // [RL12]
    else $error("open flag not set");
  chk_low_reach: assert property (ltemp_reg == ll_reg |=> status_reg[tai_pkg::ST_LLO]) // [RL13]
    else $error("low limit equality missed");
  chk_fs_drive: assert property ((fs_l_reg || fs_r_reg) |=> failsafe_overtemp_n_oe) // [RL16]
    else $error("fail-safe pin not asserted");
  chk_fs_release: assert property ( // [RL18]
    fs_l_reg && ltemp_reg <= tai_release(lfs_reg, hyst_reg)
    |=> !fs_l_reg ##1 (failsafe_overtemp_n_oe == $past(fs_r_reg)))
    else $error("fail-safe not released at hysteresis point");

endmodule : tai_alarm

`default_nettype wire

/* File: design/tai_pkg.sv */
// Constants, register map and bus states of the thermometer alarm logic.
// Assumes an SMBus master outside and a conversion engine beside the block.
package tai_pkg;
  // Bus addresses
  localparam logic [6:0] SLAVE_ADDR = 7'h4C;
  localparam logic [6:0] ARA_ADDR   = 7'h0C;
  // Read pointers
  localparam logic [7:0] RD_LTEMP   = 8'h00;
  localparam logic [7:0] RD_RTEMP   = 8'h01;
  localparam logic [7:0] RD_STATUS  = 8'h02;
  localparam logic [7:0] RD_CONFIG  = 8'h03;
  localparam logic [7:0] RD_LHIGH   = 8'h05;
  localparam logic [7:0] RD_LLOW    = 8'h06;
  localparam logic [7:0] RD_RHIGH   = 8'h07;
  localparam logic [7:0] RD_RLOW    = 8'h08;
  // Write pointers
  localparam logic [7:0] WR_CONFIG  = 8'h09;
  localparam logic [7:0] WR_LHIGH   = 8'h0B;
  localparam logic [7:0] WR_LLOW    = 8'h0C;
  localparam logic [7:0] WR_RHIGH   = 8'h0D;
  localparam logic [7:0] WR_RLOW    = 8'h0E;
  localparam logic [7:0] WR_ONESHOT = 8'h0F;
  // Shared read and write pointers
  localparam logic [7:0] RW_RFS     = 8'h19;
  localparam logic [7:0] RW_LFS     = 8'h20;
  localparam logic [7:0] RW_HYST    = 8'h21;
  // Reset values
  localparam logic [7:0] CFG_RST    = 8'h08;
  localparam logic [7:0] HIGH_RST   = 8'h55;
  localparam logic [7:0] LOW_RST    = 8'h00;
  localparam logic [7:0] FS_RST     = 8'h55;
  localparam logic [4:0] HYST_RST   = 5'h0A;
  // Configuration fields
  localparam int CFG_MASK = 7;
  localparam int CFG_STBY = 6;
  localparam int CFG_PIN2 = 5;
  // Status fields
  localparam int ST_LHI  = 6;
  localparam int ST_LLO  = 5;
  localparam int ST_RHI  = 4;
  localparam int ST_RLO  = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_RFS  = 1;
  localparam int ST_LFS  = 0;
  localparam logic [7:0] ALARM_BITS = 8'h7C;
  // Bus engine states
  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_RX,
    BUS_ACK,
    BUS_TX,
    BUS_TXACK
  } tai_bus_e;
endpackage : tai_pkg
